// file: src/vrs_pkg.sv
// Shared constants and carrier types of the reciprocal square root unit
package vrs_pkg;

    // Opcode bytes and the reserved register field value
    localparam logic [7:0] VRS_OPC_PACKED = 8'hCC;
    localparam logic [7:0] VRS_OPC_SCALAR = 8'hCD;
    localparam logic [3:0] VRS_VVVV_ONES = 4'hF;

    // Index of the last lane for each form
    localparam logic [3:0] VRS_LAST_LANE_DP = 4'h7;
    localparam logic [3:0] VRS_LAST_LANE_SP = 4'hF;
    localparam logic [3:0] VRS_LAST_LANE_SCALAR = 4'h0;

    // One result bit per cycle, bit 31 down to bit 0
    localparam logic [4:0] VRS_FIRST_BIT = 5'h1F;

    // Exponent biases and special encodings
    localparam logic [12:0] VRS_BIAS_DP = 13'h03FF;
    localparam logic [12:0] VRS_BIAS_SP = 13'h007F;
    localparam logic [63:0] VRS_QNAN_DP = 64'hFFF8_0000_0000_0000;
    localparam logic [31:0] VRS_QNAN_SP = 32'hFFC0_0000;
    localparam logic [63:0] VRS_INF_DP = 64'h7FF0_0000_0000_0000;
    localparam logic [31:0] VRS_INF_SP = 32'h7F80_0000;

    // y*y*m compared against 2^114 (y scaled by 2^31, m by 2^52)
    localparam logic [117:0] VRS_CMP_LIMIT = {4'h1, 114'h0};

    // APB register map
    localparam logic [11:0] VRS_ADDR_CTRL = 12'h000;
    localparam logic [11:0] VRS_ADDR_STATUS = 12'h004;
    localparam logic [11:0] VRS_ADDR_OPCNT = 12'h008;
    localparam logic VRS_CTRL_EN_RESET = 1'b1;
    localparam int VRS_ST_INV = 0;
    localparam int VRS_ST_DZ = 1;
    localparam int VRS_ST_UD = 2;

    typedef enum {VRS_OP_PD, VRS_OP_PS, VRS_OP_SD, VRS_OP_SS} vrs_op_type;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic width_bit;
        logic broadcast_bit;
        logic src_is_mem;
        logic [3:0] extra_source_reg_field;
        logic mask_enable;
        logic zero_masking;
        logic [15:0] lane_mask;
        logic [127:0] src1;
        logic [511:0] src2;
        logic [511:0] old_dest;
    } vrs_req_type;

    typedef struct packed {
        logic valid;
        logic [511:0] dest;
        logic flag_invalid;
        logic flag_divzero;
        logic undefined_opcode_fault;
    } vrs_resp_type;

endpackage

// file: src/vrs_unit.sv
// Reciprocal square root execution unit with APB status and control
// Notes on behaviour
// RULE1: packed single works on sixteen 32-bit lanes of a 512-bit vector.
// RULE2: packed double takes eight 64-bit lanes or one broadcast 64-bit element.
// RULE3: packed single takes 512-bit source or one broadcast 32-bit element.
// RULE4: broadcast from memory makes every lane use the lowest element.
// RULE5: inactive lanes keep old value when merging, zero when zeroing.
// RULE6: packed forms need reserved register field all ones, else fault.
// RULE7: computed results stay within 2^-28 relative error.
// RULE8: single results are rounded to below 2^-23 relative error.
// RULE9: NaN input returns itself quieted; signalling NaN sets invalid.
// RULE10: negative non-zero input gives canonical quiet NaN and invalid.
// RULE11: denormal inputs count as zero of the same sign.
// RULE12: negative zero or denormal gives negative infinity, divide-by-zero.
// RULE13: positive zero or denormal gives positive infinity, divide-by-zero.
// RULE14: only invalid and divide-by-zero flags are ever reported.
// RULE15: scalar forms compute lowest element only, gated by mask bit zero.
// RULE16: scalar double copies bits 127:64 from the first source.
// RULE17: scalar single copies bits 127:32 from the first source.
// RULE18: scalar double operand is a register or a 64-bit memory element.
// RULE19: opcode CD selects scalar double with width bit set, else single.
// RULE20: opcode CC with width bit clear selects packed single.
// RULE21: opcode CC with width bit set selects packed double.
// RULE22: plus infinity gives plus zero; powers of four give exact results.
// RULE23: scalar forms clear destination bits above 127.
`timescale 1ns/100ps
module vrs_unit
    import vrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire vrs_req_type req,
    output logic req_ready,
    output vrs_resp_type resp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);

    typedef enum {ST_IDLE, ST_LANE, ST_ITER, ST_DONE} vrs_state_type;

    vrs_state_type state;
    vrs_req_type r;
    vrs_op_type op_q;
    vrs_op_type dec_op;
    logic [3:0] lane;
    logic [3:0] last_lane;
    logic [3:0] dec_last;
    logic [4:0] bit_idx;
    logic [31:0] y;
    logic [53:0] mant_q;
    logic [12:0] exp_base_q;
    logic [511:0] work;
    logic inv_acc;
    logic dz_acc;
    logic ud_q;
    logic ctrl_en;
    logic st_inv;
    logic st_dz;
    logic st_ud;
    logic [31:0] op_count;
    logic accept;
    logic dec_fault;
    logic is_dp;
    logic lane_active;
    logic [3:0] lane_sel;
    logic [63:0] elem64;
    logic [31:0] elem32;
    logic sgn;
    logic [10:0] expf;
    logic [51:0] frac52;
    logic exp_ones;
    logic exp_zero;
    logic odd;
    logic [53:0] mant;
    logic [12:0] exp_base;
    logic spec_hit;
    logic spec_inv;
    logic spec_dz;
    logic [63:0] spec_val;
    logic [31:0] t;
    logic [63:0] sq;
    logic [117:0] prod;
    logic [31:0] y_fin;
    logic [12:0] exp_r;
    logic [23:0] rnd;
    logic [63:0] calc_val;
    logic wr_en;
    logic wr_inv;
    logic wr_dz;
    logic [63:0] wr_val;
    logic apb_fire;

    // Opcode byte and width bit decode
    always_comb begin
        dec_op = req.width_bit ? VRS_OP_PD : VRS_OP_PS; // [RULE20] [RULE21]
        dec_last = req.width_bit ? VRS_LAST_LANE_DP : VRS_LAST_LANE_SP;
        dec_fault = 1'b0;
        if (req.opcode == VRS_OPC_SCALAR) begin
            dec_op = req.width_bit ? VRS_OP_SD : VRS_OP_SS; // [RULE19]
            dec_last = VRS_LAST_LANE_SCALAR; // [RULE15]
        end else if (req.opcode != VRS_OPC_PACKED) begin
            dec_fault = 1'b1;
        end else if (req.extra_source_reg_field != VRS_VVVV_ONES) begin
            dec_fault = 1'b1; // [RULE6]
        end
    end

    assign accept = req.valid && req_ready && (state == ST_IDLE);

    // Element selection; broadcast needs a memory source
    always_comb begin
        is_dp = (op_q == VRS_OP_PD) || (op_q == VRS_OP_SD);
        lane_active = !r.mask_enable || r.lane_mask[lane]; // [RULE5] [RULE15]
        lane_sel = lane;
        if (r.broadcast_bit && r.src_is_mem) begin
            lane_sel = 4'h0; // [RULE4] [RULE2] [RULE3]
        end
        elem64 = r.src2[{lane_sel[2:0], 6'h0} +: 64]; // [RULE18]
        elem32 = r.src2[{lane_sel, 5'h0} +: 32];
    end

    // Fields into a common double-width frame
    always_comb begin
        if (is_dp) begin
            sgn = elem64[63];
            expf = elem64[62:52];
            frac52 = elem64[51:0];
            exp_ones = &elem64[62:52];
        end else begin
            sgn = elem32[31];
            expf = {3'h0, elem32[30:23]};
            frac52 = {elem32[22:0], 29'h0};
            exp_ones = &elem32[30:23];
        end
        exp_zero = (expf == 11'h0);
        // Odd unbiased exponent: fold a two into the mantissa
        odd = !expf[0];
        mant = odd ? {1'b1, frac52, 1'b0} : {2'b01, frac52};
        exp_base = (is_dp ? VRS_BIAS_DP : VRS_BIAS_SP) -
            13'($signed(13'({2'h0, expf}) - (is_dp ? VRS_BIAS_DP : VRS_BIAS_SP)
            - 13'({12'h0, odd})) >>> 1);
    end

    // Special cases; zero exponent makes denormals signed zeros
    always_comb begin
        spec_hit = 1'b1;
        spec_inv = 1'b0;
        spec_dz = 1'b0;
        spec_val = 64'h0;
        if (exp_ones && (frac52 != 52'h0)) begin
            spec_val = is_dp ? {elem64[63:52], 1'b1, elem64[50:0]} :
                {32'h0, elem32[31:23], 1'b1, elem32[21:0]}; // [RULE9]
            spec_inv = !frac52[51]; // [RULE9] [RULE14]
        end else if (exp_zero) begin
            spec_val = is_dp ? {sgn, VRS_INF_DP[62:0]} :
                {32'h0, sgn, VRS_INF_SP[30:0]}; // [RULE11] [RULE12] [RULE13]
            spec_dz = 1'b1; // [RULE14]
        end else if (sgn) begin
            spec_val = is_dp ? VRS_QNAN_DP : {32'h0, VRS_QNAN_SP}; // [RULE10]
            spec_inv = 1'b1;
        end else if (exp_ones) begin
            spec_val = 64'h0; // [RULE22]
        end else begin
            spec_hit = 1'b0;
        end
    end

    // Restoring step: keep a trial bit while y*y*m is within limit
    always_comb begin
        t = y | (32'h1 << bit_idx);
        sq = {32'h0, t} * {32'h0, t};
        prod = {54'h0, sq} * {64'h0, mant_q};
        y_fin = (prod <= VRS_CMP_LIMIT) ? t : y; // [RULE7]
        // y_fin[31] only for a mantissa of one: power of four
        exp_r = exp_base_q - {12'h0, !y_fin[31]}; // [RULE22]
        rnd = {1'b0, y_fin[29:7]} + {23'h0, y_fin[6]}; // [RULE8]
        if (is_dp) begin
            // Truncation error under 2^-30, inside the bound
            calc_val = {1'b0, exp_r[10:0],
                y_fin[31] ? 52'h0 : {y_fin[29:0], 22'h0}}; // [RULE7]
        end else if (y_fin[31]) begin
            calc_val = {32'h0, 1'b0, exp_r[7:0], 23'h0};
        end else begin
            calc_val = {32'h0, 1'b0, exp_r[7:0] + {7'h0, rnd[23]},
                rnd[23] ? 23'h0 : rnd[22:0]}; // [RULE8]
        end
    end

    // Lane write selection
    always_comb begin
        wr_en = 1'b0;
        wr_inv = 1'b0;
        wr_dz = 1'b0;
        wr_val = 64'h0;
        case (state)
            ST_LANE: begin
                if (!lane_active) begin
                    wr_en = r.zero_masking; // [RULE5]
                end else if (spec_hit) begin
                    wr_en = 1'b1;
                    wr_val = spec_val;
                    wr_inv = spec_inv;
                    wr_dz = spec_dz;
                end
            end
            ST_ITER: begin
                wr_en = (bit_idx == 5'h0);
                wr_val = calc_val;
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // Working destination and flag accumulation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work <= 512'h0;
            inv_acc <= 1'b0;
            dz_acc <= 1'b0;
        end else if (accept) begin
            inv_acc <= 1'b0;
            dz_acc <= 1'b0;
            if (dec_fault || req.opcode == VRS_OPC_PACKED) begin
                work <= req.old_dest; // [RULE5]
            end else if (req.width_bit) begin
                work <= {384'h0, req.src1[127:64], // [RULE16] [RULE23]
                    req.old_dest[63:0]};
            end else begin
                work <= {384'h0, req.src1[127:32], // [RULE17] [RULE23]
                    req.old_dest[31:0]};
            end
        end else if (wr_en) begin
            inv_acc <= inv_acc | wr_inv;
            dz_acc <= dz_acc | wr_dz;
            if (is_dp) begin
                work[{lane[2:0], 6'h0} +: 64] <= wr_val; // [RULE2]
            end else begin
                work[{lane, 5'h0} +: 32] <= wr_val[31:0]; // [RULE1]
            end
        end
    end

    // Sequencer: lanes run in turn to share one multiplier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            r <= '0;
            op_q <= VRS_OP_PD;
            lane <= 4'h0;
            last_lane <= 4'h0;
            bit_idx <= 5'h0;
            y <= 32'h0;
            mant_q <= 54'h0;
            exp_base_q <= 13'h0;
            ud_q <= 1'b0;
            req_ready <= 1'b0;
            resp <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    resp.valid <= 1'b0;
                    req_ready <= ctrl_en && !accept;
                    if (accept) begin
                        r <= req;
                        op_q <= dec_op;
                        ud_q <= dec_fault; // [RULE6]
                        lane <= 4'h0;
                        last_lane <= dec_last;
                        state <= dec_fault ? ST_DONE : ST_LANE;
                    end
                end
                ST_LANE: begin
                    if (!lane_active || spec_hit) begin
                        if (lane == last_lane) begin
                            state <= ST_DONE;
                        end else begin
                            lane <= lane + 4'h1;
                        end
                    end else begin
                        mant_q <= mant;
                        exp_base_q <= exp_base;
                        y <= 32'h0;
                        bit_idx <= VRS_FIRST_BIT;
                        state <= ST_ITER;
                    end
                end
                ST_ITER: begin
                    y <= y_fin;
                    bit_idx <= bit_idx - 5'h1;
                    if (bit_idx == 5'h0) begin
                        if (lane == last_lane) begin
                            state <= ST_DONE;
                        end else begin
                            lane <= lane + 4'h1;
                            state <= ST_LANE;
                        end
                    end
                end
                ST_DONE: begin
                    resp.valid <= 1'b1;
                    resp.dest <= work;
                    resp.flag_invalid <= inv_acc; // [RULE14]
                    resp.flag_divzero <= dz_acc;
                    resp.undefined_opcode_fault <= ud_q;
                    req_ready <= ctrl_en;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // APB slave: one wait state
    assign apb_fire = psel && penable && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            case (paddr)
                VRS_ADDR_CTRL: prdata <= {31'h0, ctrl_en};
                VRS_ADDR_STATUS: prdata <= {29'h0, st_ud, st_dz, st_inv};
                VRS_ADDR_OPCNT: prdata <= op_count;
                default: pslverr <= 1'b1;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
    end

    // Control enable; sticky status with write-one-to-clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en <= VRS_CTRL_EN_RESET;
            st_inv <= 1'b0;
            st_dz <= 1'b0;
            st_ud <= 1'b0;
            op_count <= 32'h0;
        end else begin
            if (apb_fire && pwrite && paddr == VRS_ADDR_CTRL) begin
                ctrl_en <= pwdata[0];
            end
            if (apb_fire && pwrite && paddr == VRS_ADDR_STATUS) begin
                st_inv <= (st_inv && !pwdata[VRS_ST_INV]) ||
                    (state == ST_DONE && inv_acc);
                st_dz <= (st_dz && !pwdata[VRS_ST_DZ]) ||
                    (state == ST_DONE && dz_acc);
                st_ud <= (st_ud && !pwdata[VRS_ST_UD]) ||
                    (state == ST_DONE && ud_q);
            end else if (state == ST_DONE) begin
                st_inv <= st_inv || inv_acc;
                st_dz <= st_dz || dz_acc;
                st_ud <= st_ud || ud_q;
            end
            if (state == ST_DONE) begin
                op_count <= op_count + 32'h1;
            end
        end
    end

    // Checks of the answer against the held request
    AST_PACKED_UD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        accept && req.opcode == VRS_OPC_PACKED &&
        req.extra_source_reg_field != VRS_VVVV_ONES
        |-> ##2 (resp.valid && resp.undefined_opcode_fault))
        else $error("packed form with bad register field not faulted");

    AST_PS_LATENCY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        accept && !dec_fault && dec_op == VRS_OP_PS
        |-> !resp.valid [*8] ##[10:540] resp.valid)
        else $error("packed single answer late or early");

    AST_SD_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        resp.valid && op_q == VRS_OP_SD && !resp.undefined_opcode_fault
        |-> resp.dest[127:64] == r.src1[127:64])
        else $error("scalar double upper half not from first source");

    AST_SS_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        resp.valid && op_q == VRS_OP_SS && !resp.undefined_opcode_fault
        |-> resp.dest[127:32] == r.src1[127:32])
        else $error("scalar single upper bits not from first source");

    AST_SCALAR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        resp.valid && (op_q == VRS_OP_SD || op_q == VRS_OP_SS) &&
        !resp.undefined_opcode_fault |-> resp.dest[511:128] == 384'h0)
        else $error("scalar result has non-zero bits above 127");

    AST_MASKING: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        resp.valid && op_q == VRS_OP_PS && !resp.undefined_opcode_fault &&
        r.mask_enable && !r.lane_mask[1]
        |-> resp.dest[63:32] == (r.zero_masking ? 32'h0 : r.old_dest[63:32]))
        else $error("masked lane neither merged nor zeroed");

    AST_BCAST: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        resp.valid && op_q == VRS_OP_PS && !resp.undefined_opcode_fault &&
        r.broadcast_bit && r.src_is_mem && !r.mask_enable
        |-> resp.dest[511:480] == resp.dest[31:0])
        else $error("broadcast lanes differ");

    AST_NEG_CANON: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        resp.valid && op_q == VRS_OP_SS && !resp.undefined_opcode_fault &&
        (!r.mask_enable || r.lane_mask[0]) && r.src2[31] &&
        r.src2[30:23] != 8'h0 && !(r.src2[30:23] == 8'hFF && r.src2[22:0] != 23'h0)
        |-> resp.dest[31:0] == VRS_QNAN_SP && resp.flag_invalid)
        else $error("negative input did not give canonical NaN");

    AST_POS_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        resp.valid && op_q == VRS_OP_SS && !resp.undefined_opcode_fault &&
        (!r.mask_enable || r.lane_mask[0]) && !r.src2[31] &&
        r.src2[30:23] == 8'h0
        |-> resp.dest[31:0] == VRS_INF_SP && resp.flag_divzero)
        else $error("positive zero did not give infinity");

endmodule // vrs_unit

// file: dv/vrs_issue_model.sv
// Issue stage model presenting requests
`timescale 1ns/100ps
module vrs_issue_model
    import vrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_ready,
    output vrs_req_type req
);
    // Idle at time zero: nothing offered
    initial req = '0;

    // Offer a request after a gap; hold it until taken
    task automatic send(input vrs_req_type r, input int gap);
        int n;
        repeat (gap + 1) @(posedge pclk);
        req <= r;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (req_ready !== 1'b1 && n < 2000);
        // Inverted, valid low: stale data never looks live
        req <= ~r;
    endtask
endmodule // vrs_issue_model

// file: dv/vector_recip_sqrt_approx_unit_test.sv
// Self-checking bench of the reciprocal square root unit
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module vector_recip_sqrt_approx_unit_test
    import vrs_pkg::*;
;
    logic pclk, presetn, req_ready;
    vrs_req_type req;
    vrs_resp_type resp, last;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int ops = 0;
    logic exp_inv, exp_dz;
    logic [2:0] st;
    logic [31:0] sp [16] = '{32'h0000_0000, 32'h8000_0000, 32'h0000_0001,
        32'h8000_0001, 32'hBF80_0000, 32'hFF80_0000, 32'h7F80_0000,
        32'h7FC0_1234, 32'h7F80_0001, 32'h4180_0000, 32'h3E80_0000,
        32'h3F80_0000, 32'h4040_0000, 32'h7F7F_FFFF, 32'h0080_0000,
        32'h4049_0FDB};
    logic [63:0] dps [8] = '{64'h0, 64'h8000_0000_0000_0000,
        64'h0000_0000_0000_0001, 64'hBFF0_0000_0000_0000,
        64'h7FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001,
        64'h4010_0000_0000_0000, 64'hFFF0_0000_0000_0000};

    vrs_unit dut (.pclk(pclk), .presetn(presetn), .req(req),
        .req_ready(req_ready), .resp(resp), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    vrs_issue_model u_issue (.pclk(pclk), .presetn(presetn),
        .req_ready(req_ready), .req(req));

    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer, held until pready is high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        `CHK(q, x)
        `CHK(e, xe)
    endtask

    // Single widened to double: one real check serves both
    function automatic real to_r(bit dp, logic [63:0] v);
        if (dp) return $bitstoreal(v);
        return $bitstoreal({v[31], 11'(v[30:23]) + 11'h380, v[22:0], 29'h0});
    endfunction

    // Judges one lane; notes the flags it should raise
    function automatic bit lane_ok(bit dp, logic [63:0] x, logic [63:0] y);
        logic [63:0] q, sg, inf;
        logic top, z, mz;
        real t;
        top = dp ? &x[62:52] : &x[30:23];
        z = dp ? ~|x[62:52] : ~|x[30:23];
        mz = dp ? ~|x[51:0] : ~|x[22:0];
        q = dp ? 64'h0008_0000_0000_0000 : 64'h0000_0000_0040_0000;
        sg = dp ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000;
        inf = dp ? VRS_INF_DP : {32'h0000_0000, VRS_INF_SP};
        if (top && !mz) begin
            exp_inv |= ((x & q) == 64'h0);
            return y === (x | q);
        end
        if (z) begin
            exp_dz = 1'b1;
            return y === (inf | (x & sg));
        end
        if ((x & sg) != 64'h0) begin
            exp_inv = 1'b1;
            return y === (dp ? VRS_QNAN_DP : {32'h0, VRS_QNAN_SP});
        end
        if (top) return y === 64'h0;
        t = to_r(dp, y) * $sqrt(to_r(dp, x)) - 1.0;
        if (t < 0.0) t = -t;
        return t < (dp ? 2.0 ** -28 : 2.0 ** -23);
    endfunction

    // Random legal request of one encoding
    function automatic vrs_req_type mk(logic [7:0] op, logic w);
        vrs_req_type r;
        r = '0;
        r.valid = 1'b1;
        r.opcode = op;
        r.width_bit = w;
        r.extra_source_reg_field = VRS_VVVV_ONES;
        r.broadcast_bit = 1'($urandom);
        r.src_is_mem = 1'($urandom);
        r.mask_enable = 1'($urandom);
        r.zero_masking = 1'($urandom);
        r.lane_mask = 16'($urandom);
        r.src1 = {$urandom, $urandom, $urandom, $urandom};
        for (int i = 0; i < 16; i++) begin
            r.old_dest[32*i +: 32] = $urandom;
            r.src2[32*i +: 32] = {1'b0, 8'(100 + $urandom % 56), 23'($urandom)};
        end
        if (w) for (int i = 0; i < 8; i++)
            r.src2[64*i +: 64] = {1'b0, 11'(1000 + $urandom % 48),
                20'($urandom), $urandom};
        return r;
    endfunction

    // Issue, await answer, judge every lane
    task automatic run(input vrs_req_type r);
        bit dp, pk, bc;
        int nl, n, j;
        logic [63:0] x, old, y;
        dp = r.width_bit;
        pk = (r.opcode == VRS_OPC_PACKED);
        nl = pk ? (dp ? 8 : 16) : 1;
        bc = pk && r.broadcast_bit && r.src_is_mem;
        exp_inv = 1'b0;
        exp_dz = 1'b0;
        u_issue.send(r, $urandom % 3);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (resp.valid !== 1'b1 && n < 600);
        last = resp;
        ops++;
        if (!(r.opcode == VRS_OPC_SCALAR || (pk && r.extra_source_reg_field
            == VRS_VVVV_ONES))) begin
            `CHK(last.dest, r.old_dest)
            `CHK({last.undefined_opcode_fault, last.flag_divzero}, 2'h2)
            st |= 3'h4;
            return;
        end
        for (int i = 0; i < nl; i++) begin
            j = bc ? 0 : i;
            x = dp ? r.src2[64*j +: 64] : {32'h0, r.src2[32*j +: 32]};
            old = dp ? r.old_dest[64*i +: 64] : {32'h0, r.old_dest[32*i +: 32]};
            y = dp ? last.dest[64*i +: 64] : {32'h0, last.dest[32*i +: 32]};
            if (!r.mask_enable || r.lane_mask[i])
                `CHK(lane_ok(dp, x, y), 1'b1)
            else
                `CHK(y, r.zero_masking ? 64'h0 : old)
        end
        if (!pk) begin
            `CHK(last.dest[511:128], '0)
            if (dp) `CHK(last.dest[127:64], r.src1[127:64])
            else `CHK(last.dest[127:32], r.src1[127:32])
        end
        `CHK({last.flag_divzero, last.flag_invalid}, {exp_dz, exp_inv})
        st |= {1'b0, exp_dz, exp_inv};
    endtask

    // Main sequence
    initial begin
        vrs_req_type r;
        logic [31:0] q;
        logic e;
        int f;
        f = $urandom(32'h96eaf4ef);
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        st = 3'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rchk(VRS_ADDR_CTRL, 32'h0000_0001, 1'b0);
        rchk(VRS_ADDR_STATUS, 32'h0000_0000, 1'b0);
        rchk(VRS_ADDR_OPCNT, 32'h0000_0000, 1'b0);
        rchk(12'h00C, 32'h0000_0000, 1'b1);
        // Specials: plain, merged, zeroed single, then double
        for (int k = 0; k < 4; k++) begin
            r = mk(VRS_OPC_PACKED, k == 3);
            r.broadcast_bit = 1'b0;
            r.mask_enable = (k == 1 || k == 2);
            r.zero_masking = (k == 2);
            for (int i = 0; i < 16; i++) r.src2[32*i +: 32] = sp[i];
            if (k == 3) for (int i = 0; i < 8; i++) r.src2[64*i +: 64] = dps[i];
            run(r);
            if (k == 0) `CHK(last.dest[32*9 +: 32], 32'h3E80_0000)
            if (k == 3) `CHK(last.dest[64*6 +: 64], 64'h3FE0_0000_0000_0000)
        end
        // Broadcast from memory versus from a register
        for (int k = 0; k < 4; k++) begin
            r = mk(VRS_OPC_PACKED, k[0]);
            r.broadcast_bit = 1'b1;
            r.src_is_mem = k[1];
            run(r);
        end
        // Bad reserved field, then an unknown opcode
        r = mk(VRS_OPC_PACKED, 1'b0);
        r.extra_source_reg_field = 4'hE;
        run(r);
        run(mk(8'hCE, 1'b1));
        // Random mix of all four forms
        repeat (40) begin
            f = $urandom % 4;
            run(mk(f[1] ? VRS_OPC_SCALAR : VRS_OPC_PACKED, f[0]));
        end
        rchk(VRS_ADDR_STATUS, {29'h0, st}, 1'b0);
        rchk(VRS_ADDR_OPCNT, 32'(ops), 1'b0);
        apb(1'b1, VRS_ADDR_STATUS, 32'h0000_0007, q, e);
        rchk(VRS_ADDR_STATUS, 32'h0000_0000, 1'b0);
        // Disabled unit must refuse requests
        apb(1'b1, VRS_ADDR_CTRL, 32'h0000_0000, q, e);
        repeat (2) @(posedge pclk);
        `CHK(req_ready, 1'b0)
        apb(1'b1, VRS_ADDR_CTRL, 32'h0000_0001, q, e);
        repeat (2) @(posedge pclk);
        `CHK(req_ready, 1'b1)
        print_verdict();
    end
endmodule // vector_recip_sqrt_approx_unit_test
